// ---- hw/fiap_control.sv ----
// Flash in-application programming controller with its register set
`timescale 1ns/1ns
module fiap_control import fiap_pkg::*; #(
	parameter int ERASE_T0_CYC = FIAP_ERASE_T0_CYC,
	parameter int WRITE_T0_CYC = FIAP_WRITE_T0_CYC,
	parameter int ERASE_T1_CYC = FIAP_ERASE_T1_CYC,
	parameter int WRITE_T1_CYC = FIAP_WRITE_T1_CYC,
	parameter int UNLOCK_CYC = FIAP_UNLOCK_CYC
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [3:0] sfr_addr_in,
	input wire logic sfr_wr_in,
	input wire logic [7:0] sfr_wdata_in,
	output logic [7:0] sfr_rdata_out,
	output logic cpu_stall_out,
	output logic chip_reset_out,
	output logic [11:0] flash_addr_out,
	output logic flash_erase_out,
	output logic flash_prog_out,
	output logic flash_read_out,
	input wire logic [15:0] flash_rdata_in,
	input wire logic [4:0] flash_wbuf_idx_in,
	output logic [15:0] flash_wbuf_data_out
);
	fiap_state_e state_ff;
	logic [18:0] cnt_ff;
	logic unlocked_ff;
	logic [2:0] mode_ff;
	logic read_allow_ff;
	logic time_sel_ff;
	logic [7:0] key_ff;
	logic chip_reset_ff;
	logic [11:0] addr_ff;
	logic [7:0] data_lo_ff [4];
	logic [7:0] data_hi_ff [4];
	logic [7:0] rdata_ff;
	logic wr_op, wr_key, wr_bt, wr_al, wr_ah, wr_data;
	logic [2:0] data_idx;
	logic [2:0] wmode;
	logic start_prog, start_read, start_unlock, start_clr;
	logic unlock_done, pattern_ok, first_high_wr;
	logic [18:0] prog_len;
	logic buf_we;
	logic [4:0] buf_waddr;
	logic [15:0] buf_wdata;
	logic [7:0] op_view;

	// Register write decode
	always_comb begin
		wr_op = 1'b0;
		wr_key = 1'b0;
		wr_bt = 1'b0;
		wr_al = 1'b0;
		wr_ah = 1'b0;
		wr_data = 1'b0;
		data_idx = 3'h0;
		if (sfr_addr_in == FIAP_OFS_OP_CTRL) begin
			wr_op = sfr_wr_in;
		end else if (sfr_addr_in == FIAP_OFS_RESET_KEY) begin
			wr_key = sfr_wr_in;
		end else if (sfr_addr_in == FIAP_OFS_BUF_TIME) begin
			wr_bt = sfr_wr_in;
		end else if (sfr_addr_in == FIAP_OFS_ADDR_LO) begin
			wr_al = sfr_wr_in;
		end else if (sfr_addr_in == FIAP_OFS_ADDR_HI) begin
			wr_ah = sfr_wr_in;
		end else if (sfr_addr_in >= FIAP_OFS_DATA_BASE && sfr_addr_in <= FIAP_OFS_DATA_LAST) begin
			wr_data = sfr_wr_in;
			data_idx = 3'(sfr_addr_in - FIAP_OFS_DATA_BASE);
		end
	end

	assign wmode = sfr_wdata_in[FIAP_BIT_MODE_LSB +: 3];
	assign start_prog = wr_op && sfr_wdata_in[FIAP_BIT_WRITE_GO] && state_ff == FIAP_IDLE && unlocked_ff
		&& (wmode == FIAP_MODE_WRITE || wmode == FIAP_MODE_ERASE);
	assign start_read = wr_op && sfr_wdata_in[FIAP_BIT_READ_GO] && sfr_wdata_in[FIAP_BIT_READ_ALLOW]
		&& state_ff == FIAP_IDLE && wmode == FIAP_MODE_READ;
	assign start_unlock = wr_op && sfr_wdata_in[FIAP_BIT_TRIGGER] && state_ff == FIAP_IDLE
		&& wmode == FIAP_MODE_UNLOCK;
	assign start_clr = wr_bt && sfr_wdata_in[FIAP_BIT_CLEAR_GO] && state_ff == FIAP_IDLE;
	assign unlock_done = state_ff == FIAP_UNLOCK && cnt_ff == 19'h0;
	assign first_high_wr = wr_data && data_idx == FIAP_IDX_FIRST_HIGH && state_ff == FIAP_IDLE;

	// pattern compare over words two to four
	assign pattern_ok = {data_lo_ff[1], data_lo_ff[2], data_lo_ff[3],
		data_hi_ff[1], data_hi_ff[2], data_hi_ff[3]} == FIAP_UNLOCK_PATTERN;

	always_comb begin
		if (wmode == FIAP_MODE_ERASE) begin
			prog_len = time_sel_ff ? 19'(ERASE_T1_CYC - 1) : 19'(ERASE_T0_CYC - 1);
		end else begin
			prog_len = time_sel_ff ? 19'(WRITE_T1_CYC - 1) : 19'(WRITE_T0_CYC - 1);
		end
	end

	// Operation sequencer
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state_ff <= FIAP_IDLE;
			cnt_ff <= 19'h0;
		end else begin
			case (state_ff)
				FIAP_IDLE: begin
					if (start_prog) begin
						state_ff <= (wmode == FIAP_MODE_ERASE) ? FIAP_ERASE : FIAP_PROG;
						cnt_ff <= prog_len;
					end else if (start_read) begin
						state_ff <= FIAP_READ;
						cnt_ff <= FIAP_READ_CYC - 19'h1;
					end else if (start_unlock) begin
						state_ff <= FIAP_UNLOCK;
						cnt_ff <= 19'(UNLOCK_CYC - 1);
					end else if (start_clr) begin
						state_ff <= FIAP_CLEAR;
						cnt_ff <= FIAP_CLEAR_CYC - 19'h1;
					end
				end
				FIAP_PROG: begin
					// Buffer is wiped after each page write
					if (cnt_ff == 19'h0) begin
						state_ff <= FIAP_CLEAR;
						cnt_ff <= FIAP_CLEAR_CYC - 19'h1;
					end else begin
						cnt_ff <= cnt_ff - 19'h1;
					end
				end
				FIAP_UNLOCK, FIAP_ERASE, FIAP_READ, FIAP_CLEAR: begin
					if (cnt_ff == 19'h0) begin
						state_ff <= FIAP_IDLE;
					end else begin
						cnt_ff <= cnt_ff - 19'h1;
					end
				end
				default: begin
					state_ff <= FIAP_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			unlocked_ff <= 1'b0;
		end else if (unlock_done && pattern_ok) begin
			unlocked_ff <= 1'b1;
		end else if (wr_op && !sfr_wdata_in[FIAP_BIT_UNLOCKED]) begin
			unlocked_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			mode_ff <= FIAP_RST_MODE;
			read_allow_ff <= 1'b0;
		end else if (wr_op) begin
			mode_ff <= wmode;
			read_allow_ff <= sfr_wdata_in[FIAP_BIT_READ_ALLOW];
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			time_sel_ff <= 1'b0;
		end else if (wr_bt) begin
			time_sel_ff <= sfr_wdata_in[FIAP_BIT_TIME_SEL];
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			key_ff <= FIAP_RST_BYTE;
			chip_reset_ff <= 1'b0;
		end else begin
			chip_reset_ff <= wr_key && sfr_wdata_in == FIAP_RESET_KEY;
			if (wr_key) begin
				key_ff <= sfr_wdata_in;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			addr_ff <= FIAP_RST_ADDR;
		end else if (wr_al) begin
			addr_ff[7:0] <= sfr_wdata_in;
		end else if (wr_ah) begin
			addr_ff[11:8] <= sfr_wdata_in[3:0];
		end else if (first_high_wr && addr_ff[4:0] != FIAP_PAGE_LAST) begin
			addr_ff <= addr_ff + 12'h1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			for (int i = 0; i < 4; i++) begin
				data_lo_ff[i] <= FIAP_RST_BYTE;
				data_hi_ff[i] <= FIAP_RST_BYTE;
			end
		end else if (wr_data) begin
			if (data_idx[0]) begin
				data_hi_ff[data_idx[2:1]] <= sfr_wdata_in;
			end else begin
				data_lo_ff[data_idx[2:1]] <= sfr_wdata_in;
			end
		end else if (state_ff == FIAP_READ && cnt_ff == 19'h0) begin
			{data_hi_ff[0], data_lo_ff[0]} <= flash_rdata_in;
		end
	end

	// high byte write of the first data word loads the buffer
	always_comb begin
		if (state_ff == FIAP_CLEAR) begin
			buf_we = 1'b1;
			buf_waddr = cnt_ff[4:0];
			buf_wdata = 16'h0;
		end else begin
			buf_we = first_high_wr;
			// buffer offset from address bits 4 to 0
			buf_waddr = addr_ff[4:0];
			buf_wdata = {sfr_wdata_in, data_lo_ff[0]};
		end
	end

	fiap_wbuf u_wbuf (
		.clk_in(clk_in),
		.we_in(buf_we),
		.waddr_in(buf_waddr),
		.wdata_in(buf_wdata),
		.raddr_in(flash_wbuf_idx_in),
		.rdata_out(flash_wbuf_data_out)
	);

	assign op_view = {unlocked_ff, mode_ff, state_ff == FIAP_UNLOCK,
		state_ff == FIAP_ERASE || state_ff == FIAP_PROG, read_allow_ff, state_ff == FIAP_READ};

	// register read with zeroed unused bits
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			rdata_ff <= FIAP_RST_BYTE;
		end else if (sfr_addr_in == FIAP_OFS_OP_CTRL) begin
			rdata_ff <= op_view;
		end else if (sfr_addr_in == FIAP_OFS_RESET_KEY) begin
			rdata_ff <= key_ff;
		end else if (sfr_addr_in == FIAP_OFS_BUF_TIME) begin
			rdata_ff <= {6'h0, time_sel_ff, state_ff == FIAP_CLEAR};
		end else if (sfr_addr_in == FIAP_OFS_ADDR_LO) begin
			rdata_ff <= addr_ff[7:0];
		end else if (sfr_addr_in == FIAP_OFS_ADDR_HI) begin
			rdata_ff <= {4'h0, addr_ff[11:8]};
		end else if (sfr_addr_in >= FIAP_OFS_DATA_BASE && sfr_addr_in <= FIAP_OFS_DATA_LAST) begin
			rdata_ff <= data_idx[0] ? data_hi_ff[data_idx[2:1]] : data_lo_ff[data_idx[2:1]];
		end else begin
			rdata_ff <= FIAP_RST_BYTE;
		end
	end

	assign sfr_rdata_out = rdata_ff;
	assign cpu_stall_out = state_ff == FIAP_ERASE || state_ff == FIAP_PROG || state_ff == FIAP_READ;
	assign chip_reset_out = chip_reset_ff;
	assign flash_addr_out = addr_ff;
	assign flash_erase_out = state_ff == FIAP_ERASE;
	assign flash_prog_out = state_ff == FIAP_PROG;
	assign flash_read_out = state_ff == FIAP_READ;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	unlock_set_a: assert property (
		$rose(unlocked_ff) |-> $past(unlock_done && pattern_ok)) else $error("unlock without match");
	sw_no_set_a: assert property (
		(wr_op && !unlocked_ff && !unlock_done) |=> !unlocked_ff) else $error("software set unlock");
	trigger_end_a: assert property (
		unlock_done |=> state_ff == FIAP_IDLE && !op_view[FIAP_BIT_TRIGGER]) else $error("trigger stuck");
	write_time_a: assert property (
		(start_prog && wmode == FIAP_MODE_WRITE && !time_sel_ff)
		|=> state_ff == FIAP_PROG && cnt_ff == 19'(WRITE_T0_CYC - 1)) else $error("bad write time");
	read_stall_a: assert property (
		start_read |=> (cpu_stall_out && flash_read_out)[*4] ##1 !cpu_stall_out) else $error("bad read stall");
	read_block_a: assert property (
		(wr_op && !sfr_wdata_in[FIAP_BIT_READ_ALLOW] && state_ff == FIAP_IDLE) |=> state_ff != FIAP_READ)
		else $error("read not blocked");
	chip_reset_a: assert property (
		chip_reset_out |-> $past(wr_key && sfr_wdata_in == FIAP_RESET_KEY)) else $error("bad chip reset");
	addr_step_a: assert property (
		(first_high_wr && !wr_al && !wr_ah) |=> addr_ff == (($past(addr_ff[4:0]) == FIAP_PAGE_LAST)
		? $past(addr_ff) : $past(addr_ff) + 12'h1)) else $error("bad address step");
	erase_mode_a: assert property (
		(start_prog && wmode == FIAP_MODE_ERASE) |=> flash_erase_out && cpu_stall_out) else $error("no erase");
endmodule // fiap_control

// ---- hw/fiap_wbuf.sv ----
// Page write buffer: 32 words of 16 bits, registered read port
`timescale 1ns/1ns
module fiap_wbuf (
	input wire logic clk_in,
	input wire logic we_in,
	input wire logic [4:0] waddr_in,
	input wire logic [15:0] wdata_in,
	input wire logic [4:0] raddr_in,
	output logic [15:0] rdata_out
);
	logic [15:0] mem_ff [32];
	logic [15:0] rdata_ff;

	always_ff @(posedge clk_in) begin
		if (we_in) begin
			mem_ff[waddr_in] <= wdata_in;
		end
	end

	always_ff @(posedge clk_in) begin
		rdata_ff <= mem_ff[raddr_in];
	end

	assign rdata_out = rdata_ff;
endmodule // fiap_wbuf

// ---- pkg/fiap_pkg.sv ----
// Constants used by the flash programming controller
package fiap_pkg;
	// Register offsets on the special function register port
	localparam logic [3:0] FIAP_OFS_OP_CTRL = 4'h0;
	localparam logic [3:0] FIAP_OFS_RESET_KEY = 4'h1;
	localparam logic [3:0] FIAP_OFS_BUF_TIME = 4'h2;
	localparam logic [3:0] FIAP_OFS_ADDR_LO = 4'h3;
	localparam logic [3:0] FIAP_OFS_ADDR_HI = 4'h4;
	// Data word pairs: low byte at base+2n, high byte at base+2n+1
	localparam logic [3:0] FIAP_OFS_DATA_BASE = 4'h5;
	localparam logic [3:0] FIAP_OFS_DATA_LAST = 4'hc;
	localparam logic [2:0] FIAP_IDX_FIRST_HIGH = 3'h1;
	// Operation control bit positions
	localparam int FIAP_BIT_UNLOCKED = 7;
	localparam int FIAP_BIT_MODE_LSB = 4;
	localparam int FIAP_BIT_TRIGGER = 3;
	localparam int FIAP_BIT_WRITE_GO = 2;
	localparam int FIAP_BIT_READ_ALLOW = 1;
	localparam int FIAP_BIT_READ_GO = 0;
	// Buffer and timing control bit positions
	localparam int FIAP_BIT_TIME_SEL = 1;
	localparam int FIAP_BIT_CLEAR_GO = 0;
	// Reset values
	localparam logic [7:0] FIAP_RST_BYTE = 8'h00;
	localparam logic [11:0] FIAP_RST_ADDR = 12'h000;
	localparam logic [2:0] FIAP_RST_MODE = 3'h0;
	// Operation modes
	localparam logic [2:0] FIAP_MODE_WRITE = 3'h0;
	localparam logic [2:0] FIAP_MODE_ERASE = 3'h1;
	localparam logic [2:0] FIAP_MODE_READ = 3'h3;
	localparam logic [2:0] FIAP_MODE_UNLOCK = 3'h6;
	// Chip reset key and unlock pattern
	localparam logic [7:0] FIAP_RESET_KEY = 8'h55;
	localparam logic [47:0] FIAP_UNLOCK_PATTERN = 48'h00_0d_c3_04_09_40;
	// Page geometry
	localparam logic [4:0] FIAP_PAGE_LAST = 5'h1f;
	// Timing
	localparam int FIAP_CLK_PERIOD_NS = 10;
	localparam int FIAP_ERASE_T0_NS = 3200000;
	localparam int FIAP_WRITE_T0_NS = 2200000;
	localparam int FIAP_ERASE_T1_NS = 3700000;
	localparam int FIAP_WRITE_T1_NS = 3000000;
	localparam int FIAP_ERASE_T0_CYC = FIAP_ERASE_T0_NS / FIAP_CLK_PERIOD_NS;
	localparam int FIAP_WRITE_T0_CYC = FIAP_WRITE_T0_NS / FIAP_CLK_PERIOD_NS;
	localparam int FIAP_ERASE_T1_CYC = FIAP_ERASE_T1_NS / FIAP_CLK_PERIOD_NS;
	localparam int FIAP_WRITE_T1_CYC = FIAP_WRITE_T1_NS / FIAP_CLK_PERIOD_NS;
	localparam int FIAP_UNLOCK_CYC = 64;
	localparam logic [18:0] FIAP_READ_CYC = 19'h4;
	localparam logic [18:0] FIAP_CLEAR_CYC = 19'h20;
	typedef enum logic [2:0] {
		FIAP_IDLE = 3'b000,
		FIAP_UNLOCK = 3'b001,
		FIAP_ERASE = 3'b010,
		FIAP_PROG = 3'b011,
		FIAP_READ = 3'b100,
		FIAP_CLEAR = 3'b101
	} fiap_state_e;
endpackage

// ---- sim/fiap_flash_model.sv ----
// Behavioural flash array on the far side of the programming controller
`timescale 1ns/1ns
module fiap_flash_model (
	input wire logic clk_in,
	input wire logic [11:0] addr_in,
	input wire logic erase_in,
	input wire logic prog_in,
	input wire logic read_in,
	input wire logic [15:0] wbuf_data_in,
	output logic [4:0] wbuf_idx_out,
	output logic [15:0] rdata_out
);
	logic [15:0] mem [0:4095];
	logic [4:0] idx_d;
	logic cap_ff;
	initial begin
		wbuf_idx_out = 5'h00;
		idx_d = 5'h00;
		cap_ff = 1'b0;
		for (int i = 0; i < 4096; i++) mem[i] = 16'h5a5a ^ 16'(i);
	end
	always @(posedge clk_in) begin
		if (erase_in)
			for (int i = 0; i < 32; i++) mem[{addr_in[11:5], 5'(i)}] <= 16'h0000;
		if (cap_ff)
			mem[{addr_in[11:5], idx_d}] <= wbuf_data_in;
		cap_ff <= prog_in;
		idx_d <= wbuf_idx_out;
		wbuf_idx_out <= prog_in ? wbuf_idx_out + 5'h01 : 5'h00;
	end
	// Outside a read the data lines show inverted data
	assign rdata_out = read_in ? mem[addr_in] : ~mem[addr_in];
endmodule // fiap_flash_model

// ---- sim/tb.sv ----
// Self-checking bench for the flash programming controller
`timescale 1ns/1ns
module tb;
	localparam int ER0 = 20;
	localparam int ER1 = 30;
	localparam int WR0 = 40;
	localparam int WR1 = 50;
	localparam int UNL = 24;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic [3:0] sfr_addr_in = 4'h0;
	logic sfr_wr_in = 1'b0;
	logic [7:0] sfr_wdata_in = 8'h00;
	logic [7:0] sfr_rdata_out;
	logic cpu_stall_out, chip_reset_out, flash_erase_out, flash_prog_out, flash_read_out;
	logic [11:0] flash_addr_out;
	logic [15:0] flash_rdata_in, flash_wbuf_data_out;
	logic [4:0] flash_wbuf_idx_in;
	logic rd_pend = 1'b0;
	logic [7:0] exp_q [$];
	logic [7:0] rv [6];
	logic [2:0] rsv [4] = '{3'h2, 3'h4, 3'h5, 3'h7};
	int error_cnt = 0;
	int tests_run = 0;
	int n_st = 0, n_er = 0, n_pg = 0, n_rd = 0, n_cr = 0;
	int s0, e0, p0, r0, c0;
	always #5 clk_in = ~clk_in;
	fiap_control #(.ERASE_T0_CYC(ER0), .WRITE_T0_CYC(WR0), .ERASE_T1_CYC(ER1), .WRITE_T1_CYC(WR1),
		.UNLOCK_CYC(UNL)) uut (.clk_in(clk_in), .rst_in(rst_in), .sfr_addr_in(sfr_addr_in),
		.sfr_wr_in(sfr_wr_in), .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out),
		.cpu_stall_out(cpu_stall_out), .chip_reset_out(chip_reset_out), .flash_addr_out(flash_addr_out),
		.flash_erase_out(flash_erase_out), .flash_prog_out(flash_prog_out), .flash_read_out(flash_read_out),
		.flash_rdata_in(flash_rdata_in), .flash_wbuf_idx_in(flash_wbuf_idx_in),
		.flash_wbuf_data_out(flash_wbuf_data_out));
	fiap_flash_model fm (.clk_in(clk_in), .addr_in(flash_addr_out), .erase_in(flash_erase_out),
		.prog_in(flash_prog_out), .read_in(flash_read_out), .wbuf_data_in(flash_wbuf_data_out),
		.wbuf_idx_out(flash_wbuf_idx_in), .rdata_out(flash_rdata_in));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_in);
		sfr_addr_in <= a;
		sfr_wdata_in <= d;
		sfr_wr_in <= 1'b1;
		@(posedge clk_in);
		sfr_wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk_in);
		sfr_addr_in <= a;
		exp_q.push_back(e);
		rd_pend <= 1'b1;
		@(posedge clk_in);
		rd_pend <= 1'b0;
	endtask
	// Counts busy cycles and compares each register read with its note
	always @(posedge clk_in) begin
		n_st += cpu_stall_out;
		n_er += flash_erase_out;
		n_pg += flash_prog_out;
		n_rd += flash_read_out;
		n_cr += chip_reset_out;
		if (rd_pend) begin
			@(negedge clk_in);
			chk(sfr_rdata_out, exp_q.pop_front());
		end
	end
	task automatic op(input logic [7:0] v, input int st, input int er, input int pg, input int rdc);
		int i;
		s0 = n_st;
		e0 = n_er;
		p0 = n_pg;
		r0 = n_rd;
		wr(4'h0, v);
		@(negedge clk_in);
		for (i = 0; i < 2000 && cpu_stall_out !== 1'b0; i++)
			@(negedge clk_in);
		if (i == 2000) begin
			error_cnt++;
			tally_and_finish();
		end
		chk(n_st - s0, st);
		chk(n_er - e0, er);
		chk(n_pg - p0, pg);
		chk(n_rd - r0, rdc);
	endtask
	task automatic unlock(input logic [7:0] last, input logic [7:0] after);
		logic [7:0] pat [6] = '{8'h00, 8'h04, 8'h0d, 8'h09, 8'hc3, last};
		wr(4'h0, 8'h68);
		for (int i = 0; i < 6; i++) wr(4'(7 + i), pat[i]);
		rd(4'h0, 8'h68);
		repeat (UNL) @(posedge clk_in);
		rd(4'h0, after);
	endtask
	initial begin
		void'($urandom(32'hc094));
		repeat (10) @(posedge clk_in);
		rst_in <= 1'b0;
		for (int a = 0; a < 16; a++) rd(4'(a), 8'h00);
		wr(4'h0, 8'h80);
		rd(4'h0, 8'h00);
		op(8'h04, 0, 0, 0, 0);
		c0 = n_cr;
		wr(4'h1, 8'h54);
		wr(4'h1, 8'h55);
		repeat (2) @(posedge clk_in);
		chk(n_cr - c0, 1);
		rd(4'h1, 8'h55);
		for (int i = 0; i < 6; i++) begin
			rv[i] = 8'($urandom);
			wr(4'(7 + i), rv[i]);
		end
		for (int i = 0; i < 6; i++) rd(4'(7 + i), rv[i]);
		unlock(8'h41, 8'h60);
		unlock(8'h40, 8'he0);
		op(8'hb1, 0, 0, 0, 0);
		rd(4'h0, 8'hb0);
		wr(4'h3, 8'h1e);
		wr(4'h4, 8'hf5);
		rd(4'h4, 8'h05);
		wr(4'h5, 8'hab);
		rd(4'h3, 8'h1e);
		wr(4'h6, 8'hcd);
		rd(4'h3, 8'h1f);
		chk(flash_addr_out, 12'h51f);
		wr(4'h6, 8'hcd);
		rd(4'h3, 8'h1f);
		rd(4'h4, 8'h05);
		op(8'h94, ER0, ER0, 0, 0);
		wr(4'h2, 8'h02);
		op(8'h94, ER1, ER1, 0, 0);
		rd(4'h0, 8'h90);
		op(8'h84, WR1, 0, WR1, 0);
		rd(4'h2, 8'h03);
		repeat (34) @(posedge clk_in);
		rd(4'h2, 8'h02);
		rd(4'h0, 8'h80);
		wr(4'h3, 8'h1e);
		wr(4'h5, 8'h00);
		op(8'hb3, 4, 0, 0, 4);
		rd(4'h0, 8'hb2);
		rd(4'h5, 8'hab);
		rd(4'h6, 8'hcd);
		wr(4'h2, 8'h01);
		rd(4'h2, 8'h01);
		repeat (34) @(posedge clk_in);
		rd(4'h2, 8'h00);
		op(8'h84, WR0, 0, WR0, 0);
		repeat (34) @(posedge clk_in);
		op(8'hb3, 4, 0, 0, 4);
		rd(4'h5, 8'h00);
		rd(4'h6, 8'h00);
		for (int m = 0; m < 4; m++) begin
			op({1'b1, rsv[m], 4'h4}, 0, 0, 0, 0);
			rd(4'h0, {1'b1, rsv[m], 4'h0});
		end
		wr(4'h0, 8'h00);
		rd(4'h0, 8'h00);
		op(8'h04, 0, 0, 0, 0);
		repeat (2) @(posedge clk_in);
		tally_and_finish();
	end
endmodule // tb
